// file: aie_core.sv
// Purpose: executes add instructions in four quarter phases
// Assumes: software feeds instruction words over Wishbone
// Notes: bus accesses stall while an instruction is in flight
// Notes on behaviour
// RULE1 - port read-modify-write uses sensed pin levels, not the output latch
// RULE2 - result written to timer count clears prescaler when it is assigned
// RULE3 - branches and goto completion take two cycles, second does nothing
// RULE4 - a lone second word of a two-word instruction acts as no-op
// RULE5 - add-file sums accumulator and file byte, sets all five flags
// RULE6 - destination bit 0 writes accumulator, 1 writes the file byte
// RULE7 - access bit 0 uses access bank, 1 uses bank select register
// RULE8 - access bit 0 with extended set and address up to 5Fh is indexed
// RULE9 - add-literal adds the literal into accumulator, sets all flags
// RULE10 - decode, read, arithmetic and write occupy quarters one to four
// RULE11 - add-file is one word, one cycle, full 256-byte bank reach
`timescale 1ns/1ps
`default_nettype none
module aie_core
   import aie_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [7:0] portPins,
   output logic [7:0] secondPortReg
);
   aie_state_t state, next_state;
   logic [1:0] phase;
   logic [15:0] instrWord;
   logic [2:0] ctrl;
   logic [7:0] accumulatorFileReg, timerZeroCount, prescaler;
   logic [7:0] pinSample, operand, result, gotoLow;
   logic [3:0] bankSelectReg;
   logic [11:0] indexBase, memAddr, exAddr;
   logic [20:0] instructionPointer;
   logic carryFlag, digitCarryFlag, zeroFlag, overflowFlag, negativeFlag;
   logic wordPending, busPend;
   logic [7:0] ramRdata;
   logic [31:0] selMask;

   // bus decode
   wire logic [7:0] regOff = {wb_adr_i[7:2], 2'b00};
   wire logic busy = state != AIE_IDLE;
   wire logic busWrite = busPend && wb_we_i;
   wire logic selCtrl = regOff == REG_CTRL;
   wire logic selInstr = regOff == REG_INSTR;
   wire logic selAcc = regOff == REG_ACC;
   wire logic selBank = regOff == REG_BANK;
   wire logic selIndex = regOff == REG_INDEX;
   wire logic selMemAddr = regOff == REG_MEMADDR;
   wire logic selMemData = regOff == REG_MEMDATA;
   wire logic selTimer = regOff == REG_TIMER;
   wire logic selPort = regOff == REG_PORT;
   wire logic startExec = busWrite && selInstr && !busy;

   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_lane
         assign selMask[8*g +: 8] = {8{wb_sel_i[g]}};
      end
   endgenerate

   function automatic logic [31:0] mrg(input logic [31:0] old);
      return (old & ~selMask) | (wb_dat_i & selMask);
   endfunction

   wire logic [31:0] mCtrl = mrg({29'h0, ctrl});
   wire logic [31:0] mInstr = mrg({16'h0, instrWord});
   wire logic [31:0] mAcc = mrg({24'h0, accumulatorFileReg});
   wire logic [31:0] mBank = mrg({28'h0, bankSelectReg});
   wire logic [31:0] mIndex = mrg({20'h0, indexBase});
   wire logic [31:0] mMemAddr = mrg({20'h0, memAddr});
   wire logic [31:0] mTimer = mrg({24'h0, timerZeroCount});
   wire logic [31:0] mPort = mrg({24'h0, secondPortReg});

   wire logic [31:0] statusWord = {22'h0, wordPending, busy, 3'h0,
      negativeFlag, overflowFlag, zeroFlag, digitCarryFlag, carryFlag};
   wire logic [31:0] rdWord =
      selCtrl ? {29'h0, ctrl} :
      selInstr ? {16'h0, instrWord} :
      (regOff == REG_STATUS) ? statusWord :
      selAcc ? {24'h0, accumulatorFileReg} :
      selBank ? {28'h0, bankSelectReg} :
      selIndex ? {20'h0, indexBase} :
      (regOff == REG_IPTR) ? {11'h0, instructionPointer} :
      selMemAddr ? {20'h0, memAddr} :
      selMemData ? {24'h0, ramRdata} :
      selTimer ? {24'h0, timerZeroCount} :
      (regOff == REG_PRESC) ? {24'h0, prescaler} :
      selPort ? {24'h0, secondPortReg} : 32'h00000000;

   // instruction decode
   wire logic isAddLit = instrWord[15:8] == OPC_ADD_LIT;
   wire logic isAddFile = instrWord[15:10] == OPC_ADD_FILE;
   wire logic isBranch = instrWord[15:11] == OPC_BRANCH;
   wire logic isGoto = instrWord[15:8] == OPC_GOTO;
   wire logic isSecond = instrWord[15:12] == OPC_SECOND;
   wire logic gotoDone = wordPending && isSecond;
   wire logic twoCycle = isBranch || gotoDone;
   wire logic [7:0] fileAddr = instrWord[7:0];
   wire logic destFile = instrWord[9];
   wire logic banked = instrWord[8];
   wire logic indexed = !banked && ctrl[CTRL_EXT] && fileAddr <= INDEXED_MAX;
   wire logic [11:0] accessAddr = (fileAddr < ACCESS_SPLIT) ?
      {ACCESS_LOW_BANK, fileAddr} : {ACCESS_HIGH_BANK, fileAddr};
   wire logic [11:0] effAddr = indexed ? 12'(indexBase + {4'h0, fileAddr}) :
      banked ? {bankSelectReg, fileAddr} : accessAddr;
   wire logic inQ1 = state == AIE_EXEC && phase == PH_Q1;
   wire logic inQ2 = state == AIE_EXEC && phase == PH_Q2;
   wire logic inQ3 = state == AIE_EXEC && phase == PH_Q3;
   wire logic inQ4 = state == AIE_EXEC && phase == PH_Q4;
   wire logic atPort = exAddr == PORT_ADDR;
   wire logic atTimer = exAddr == TIMER_ADDR;
   wire logic accDest = isAddLit || (isAddFile && !destFile);
   wire logic fileDest = isAddFile && destFile;
   wire logic timerWrite = inQ4 && fileDest && atTimer;
   wire logic [7:0] operandSel = isAddLit ? instrWord[7:0] :
      atPort ? pinSample : atTimer ? timerZeroCount : ramRdata;
   wire logic [8:0] sum9 = {1'b0, accumulatorFileReg} + {1'b0, operandSel};
   wire logic [4:0] nib5 = {1'b0, accumulatorFileReg[3:0]} +
      {1'b0, operandSel[3:0]};
   wire logic [20:0] ipStep = 21'(instructionPointer + IPTR_STEP);
   wire logic [20:0] braOff = {{9{instrWord[10]}}, instrWord[10:0], 1'b0};
   wire logic [20:0] next_ip = gotoDone ? {instrWord[11:0], gotoLow, 1'b0} :
      isBranch ? 21'(ipStep + braOff) : isGoto ? instructionPointer : ipStep;
   wire logic ramWe = (inQ4 && fileDest && !atPort && !atTimer) ||
      (busWrite && selMemData && wb_sel_i[0]);
   wire logic [11:0] ramAddr = busy ? exAddr : memAddr;
   wire logic [7:0] ramWdata = busy ? result : wb_dat_i[7:0];
   wire logic [1:0] next_phase = (state == AIE_IDLE) ? PH_Q1 :
      2'(phase + 2'h1);

   always_comb
   begin
      next_state = state;
      case (state)
         AIE_IDLE:
            if (startExec)
               next_state = AIE_EXEC;
         AIE_EXEC:
            if (phase == PH_Q4)
               next_state = twoCycle ? AIE_FLUSH : AIE_IDLE; // RULE3 RULE11
         AIE_FLUSH:
            if (phase == PH_Q4)
               next_state = AIE_IDLE; // RULE3
         default:
            next_state = AIE_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         state <= AIE_IDLE;
         phase <= PH_Q1;
      end
      else
      begin
         state <= next_state;
         phase <= next_phase; // RULE10
      end
   end

   // wishbone slave, ack two edges after request
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         busPend <= 1'b0;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         busPend <= wb_cyc_i && wb_stb_i && !busPend && !wb_ack_o && !busy;
         wb_ack_o <= busPend;
         wb_dat_o <= busPend ? rdWord : 32'h00000000;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         ctrl <= CTRL_RST;
         bankSelectReg <= 4'h0;
         indexBase <= ADDR_RST;
         memAddr <= ADDR_RST;
      end
      else if (busWrite)
      begin
         if (selCtrl)
            ctrl <= mCtrl[2:0];
         if (selBank)
            bankSelectReg <= mBank[3:0];
         if (selIndex)
            indexBase <= mIndex[11:0];
         if (selMemAddr)
            memAddr <= mMemAddr[11:0];
      end
   end

   // decode, read, process
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         instrWord <= INSTR_RST;
         exAddr <= ADDR_RST;
         pinSample <= BYTE_RST;
         operand <= BYTE_RST;
         result <= BYTE_RST;
      end
      else
      begin
         if (startExec)
            instrWord <= mInstr[15:0];
         if (inQ1)
            exAddr <= effAddr; // RULE7 RULE8 RULE11
         if (inQ2)
            pinSample <= portPins; // RULE1
         if (inQ3)
         begin
            operand <= operandSel;
            result <= sum9[7:0]; // RULE5 RULE9
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         carryFlag <= 1'b0;
         digitCarryFlag <= 1'b0;
         zeroFlag <= 1'b0;
         overflowFlag <= 1'b0;
         negativeFlag <= 1'b0;
      end
      else if (inQ3 && (isAddLit || isAddFile))
      begin
         carryFlag <= sum9[8]; // RULE5 RULE9
         digitCarryFlag <= nib5[4];
         zeroFlag <= sum9[7:0] == 8'h00;
         overflowFlag <= (accumulatorFileReg[7] == operandSel[7]) &&
            (sum9[7] != accumulatorFileReg[7]);
         negativeFlag <= sum9[7];
      end
   end

   // destination write and flow
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         accumulatorFileReg <= BYTE_RST;
         secondPortReg <= BYTE_RST;
         instructionPointer <= IPTR_RST;
         wordPending <= 1'b0;
         gotoLow <= BYTE_RST;
      end
      else
      begin
         if (inQ4 && accDest)
            accumulatorFileReg <= result; // RULE6 RULE9
         else if (busWrite && selAcc)
            accumulatorFileReg <= mAcc[7:0];
         if (inQ4 && fileDest && atPort)
            secondPortReg <= result; // RULE6
         else if (busWrite && selPort)
            secondPortReg <= mPort[7:0];
         if (inQ4)
         begin
            instructionPointer <= next_ip; // RULE3 RULE4
            wordPending <= isGoto;
            gotoLow <= isGoto ? instrWord[7:0] : gotoLow;
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         timerZeroCount <= BYTE_RST;
         prescaler <= BYTE_RST;
      end
      else
      begin
         if (timerWrite)
            timerZeroCount <= result;
         else if (busWrite && selTimer)
            timerZeroCount <= mTimer[7:0];
         else if (ctrl[CTRL_RUN] && (!ctrl[CTRL_PSA] || prescaler == PRESC_FULL))
            timerZeroCount <= 8'(timerZeroCount + 8'h01);
         if (timerWrite && ctrl[CTRL_PSA])
            prescaler <= BYTE_RST; // RULE2
         else if (ctrl[CTRL_RUN] && ctrl[CTRL_PSA])
            prescaler <= 8'(prescaler + 8'h01);
      end
   end

   aie_file_ram u_ram
   (
      .sys_clk(sys_clk),
      .writeEn(ramWe),
      .addr(ramAddr),
      .writeData(ramWdata),
      .readData(ramRdata)
   );

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   property p_port_pins;
      inQ4 && isAddFile && atPort |->
         result == 8'(accumulatorFileReg + $past(portPins, 2));
   endproperty
   a_port_pins: assert property (p_port_pins) else $error("port read not pins"); // RULE1
   property p_presc_clear;
      timerWrite && ctrl[CTRL_PSA] |=> prescaler == 8'h00;
   endproperty
   a_presc_clear: assert property (p_presc_clear) else $error("prescaler kept"); // RULE2
   property p_two_cycle;
      inQ4 && isBranch |=> (state == AIE_FLUSH)[*4] ##1 state == AIE_IDLE;
   endproperty
   a_two_cycle: assert property (p_two_cycle) else $error("branch not 2 cycles"); // RULE3
   property p_lone_second;
      inQ4 && isSecond && !wordPending |=>
         instructionPointer == 21'($past(instructionPointer) + IPTR_STEP) &&
         $stable(accumulatorFileReg) && state == AIE_IDLE;
   endproperty
   a_lone_second: assert property (p_lone_second) else $error("second word ran"); // RULE4
   property p_add_flags;
      inQ4 && isAddFile |-> {carryFlag, result} ==
         9'({1'b0, accumulatorFileReg} + {1'b0, operand}) &&
         zeroFlag == (result == 8'h00) && negativeFlag == result[7];
   endproperty
   a_add_flags: assert property (p_add_flags) else $error("add sum wrong"); // RULE5
   property p_dest_acc;
      inQ4 && isAddFile && !destFile |=> accumulatorFileReg == $past(result);
   endproperty
   a_dest_acc: assert property (p_dest_acc) else $error("acc not written"); // RULE6
   property p_banked;
      inQ1 && isAddFile && banked |=>
         exAddr == {$past(bankSelectReg), $past(fileAddr)};
   endproperty
   a_banked: assert property (p_banked) else $error("bank addr wrong"); // RULE7
   property p_indexed;
      inQ1 && isAddFile && indexed |=>
         exAddr == 12'($past(indexBase) + {4'h0, $past(fileAddr)});
   endproperty
   a_indexed: assert property (p_indexed) else $error("indexed addr wrong"); // RULE8
   property p_add_lit;
      inQ3 && isAddLit |=> ##1 accumulatorFileReg ==
         8'($past(accumulatorFileReg, 2) + $past(instrWord[7:0], 2));
   endproperty
   a_add_lit: assert property (p_add_lit) else $error("literal add wrong"); // RULE9
   property p_phases;
      inQ1 |=> inQ2 ##1 inQ3 ##1 inQ4;
   endproperty
   a_phases: assert property (p_phases) else $error("phase order wrong"); // RULE10
   property p_one_cycle;
      inQ1 && isAddFile |-> ##4 state == AIE_IDLE;
   endproperty
   a_one_cycle: assert property (p_one_cycle) else $error("add not 1 cycle"); // RULE11
   c_add_lit: cover property (inQ4 && isAddLit);
   c_add_file: cover property (inQ4 && fileDest && !atPort && !atTimer);
   c_branch: cover property (state == AIE_FLUSH && phase == PH_Q4);
   c_timer: cover property (timerWrite && ctrl[CTRL_PSA]);
endmodule // aie_core
`default_nettype wire

// file: aie_pkg.sv
// Purpose: shared constants and types of the add-instruction execute block
// Assumes: byte offsets on a 32-bit classic Wishbone slave
// Notes: special-function addresses sit in the top bank of file memory
`default_nettype none
package aie_pkg;
   localparam int MEM_AW = 12;
   localparam int MEM_DEPTH = 4096;
   // register byte offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_INSTR = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_ACC = 8'h0C;
   localparam logic [7:0] REG_BANK = 8'h10;
   localparam logic [7:0] REG_INDEX = 8'h14;
   localparam logic [7:0] REG_IPTR = 8'h18;
   localparam logic [7:0] REG_MEMADDR = 8'h1C;
   localparam logic [7:0] REG_MEMDATA = 8'h20;
   localparam logic [7:0] REG_TIMER = 8'h24;
   localparam logic [7:0] REG_PRESC = 8'h28;
   localparam logic [7:0] REG_PORT = 8'h2C;
   // control bit positions
   localparam int CTRL_EXT = 0;
   localparam int CTRL_PSA = 1;
   localparam int CTRL_RUN = 2;
   // reset values
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [20:0] IPTR_RST = 21'h000000;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [11:0] ADDR_RST = 12'h000;
   localparam logic [15:0] INSTR_RST = 16'h0000;
   // file addressing
   localparam logic [11:0] PORT_ADDR = 12'hF90;
   localparam logic [11:0] TIMER_ADDR = 12'hF91;
   localparam logic [7:0] INDEXED_MAX = 8'h5F;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   // opcode fields
   localparam logic [7:0] OPC_ADD_LIT = 8'h0F;
   localparam logic [5:0] OPC_ADD_FILE = 6'h09;
   localparam logic [4:0] OPC_BRANCH = 5'h1A;
   localparam logic [7:0] OPC_GOTO = 8'hEF;
   localparam logic [3:0] OPC_SECOND = 4'hF;
   localparam logic [20:0] IPTR_STEP = 21'h000002;
   localparam logic [7:0] PRESC_FULL = 8'hFF;
   // quarter phases
   localparam logic [1:0] PH_Q1 = 2'h0;
   localparam logic [1:0] PH_Q2 = 2'h1;
   localparam logic [1:0] PH_Q3 = 2'h2;
   localparam logic [1:0] PH_Q4 = 2'h3;
   typedef enum logic [1:0]
   {
      AIE_IDLE = 2'b00,
      AIE_EXEC = 2'b01,
      AIE_FLUSH = 2'b10
   } aie_state_t;
endpackage
`default_nettype wire

// file: aie_file_ram.sv
// Purpose: data memory of the core, registered read
// Assumes: one port, read and write share the address
// Notes: read data show the cell addressed at the previous edge
`timescale 1ns/1ps
`default_nettype none
module aie_file_ram
   import aie_pkg::*;
(
   input wire logic sys_clk,
   input wire logic writeEn,
   input wire logic [MEM_AW-1:0] addr,
   input wire logic [7:0] writeData,
   output logic [7:0] readData
);
   logic [7:0] cells [0:MEM_DEPTH-1];

   always_ff @(posedge sys_clk)
   begin
      if (writeEn)
         cells[addr] <= writeData;
      readData <= cells[addr];
   end
endmodule // aie_file_ram
`default_nettype wire

// file: aie_prog_mem.sv
// Purpose: program memory model feeding 16-bit instruction words
// Assumes: word chosen by index, answer is combinational
// Notes: unlisted indices give a lone second-word pattern
`timescale 1ns/1ps
`default_nettype none
module aie_prog_mem
(
   input wire logic [3:0] wordIdx,
   output logic [15:0] instrWord
);
   always_comb
   begin
      case (wordIdx)
         4'h0: instrWord = 16'h0F15;
         4'h1: instrWord = 16'h0F80;
         4'h2: instrWord = 16'h2410;
         4'h3: instrWord = 16'h2734;
         4'h4: instrWord = 16'h2690;
         4'h5: instrWord = 16'h2691;
         4'h6: instrWord = 16'h245F;
         4'h7: instrWord = 16'h2460;
         4'h8: instrWord = 16'hD003;
         4'h9: instrWord = 16'hEF12;
         4'hA: instrWord = 16'hF034;
         default: instrWord = 16'hF0AA;
      endcase
   end
endmodule // aie_prog_mem
`default_nettype wire

// file: add_instruction_execute_tb.sv
// Purpose: self-checking bench of the add execute core
// Assumes: classic Wishbone single cycles, words from program memory
// Notes: every wait is bounded, a spent bound fails the run
`timescale 1ns/1ps
`default_nettype none
module add_instruction_execute_tb
   import aie_pkg::*;
;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic wbCyc = 1'b0;
   logic wbStb = 1'b0;
   logic wbWe = 1'b0;
   logic [7:0] wbAdr = 8'h00;
   logic [3:0] wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h00000000;
   logic [31:0] wbDatO;
   logic wbAck;
   logic [7:0] portPins = 8'h00;
   logic [7:0] secondPortReg;
   logic [3:0] progIdx = 4'h0;
   logic [15:0] progWord;
   logic [31:0] rd;
   logic [31:0] ip;
   int n_fail = 0;
   int num_checks = 0;
   `define CHK(got, exp) \
      begin \
         num_checks++; \
         if ((got) !== (exp)) \
         begin \
            n_fail++; \
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp); \
         end \
      end
   aie_core i_dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wbCyc),
      .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
      .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO),
      .wb_ack_o(wbAck), .portPins(portPins),
      .secondPortReg(secondPortReg));
   aie_prog_mem i_prog (.wordIdx(progIdx), .instrWord(progWord));
   initial
   begin
      forever #2 sys_clk = ~sys_clk;
   end
   task print_verdict;
      if (n_fail == 0 && num_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task xfer(input logic isWr, input logic [7:0] adr,
      input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= isWr;
      wbAdr <= adr;
      wbSel <= 4'hF;
      wbDatI <= d;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while (wbAck !== 1'b1 && n < 400);
      q = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe <= 1'b0;
      if (wbAck !== 1'b1)
      begin
         n_fail++;
         print_verdict();
      end
   endtask
   task wr(input logic [7:0] adr, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, adr, d, q);
   endtask
   task chk(input logic [7:0] adr, input logic [31:0] exp);
      logic [31:0] q;
      xfer(1'b0, adr, 32'h00000000, q);
      `CHK(q, exp)
   endtask
   task exe(input logic [3:0] idx);
      progIdx <= idx;
      @(posedge sys_clk);
      wr(REG_INSTR, {16'h0000, progWord});
   endtask
   initial
   begin
      repeat (10) @(posedge sys_clk);
      reset <= 1'b0;
      chk(REG_CTRL, 32'h0);
      chk(REG_IPTR, 32'h0);
      wr(8'h30, 32'h5A);
      chk(8'h30, 32'h0);
      wr(REG_ACC, 32'h10);
      exe(4'h0);
      chk(REG_ACC, 32'h25);
      chk(REG_STATUS, 32'h0);
      wr(REG_ACC, 32'h80);
      exe(4'h1);
      chk(REG_ACC, 32'h0);
      chk(REG_STATUS, 32'h0D);
      wr(REG_MEMADDR, 32'h010);
      wr(REG_MEMDATA, 32'hC2);
      wr(REG_ACC, 32'h17);
      exe(4'h2);
      chk(REG_ACC, 32'hD9);
      chk(REG_STATUS, 32'h10);
      chk(REG_MEMDATA, 32'hC2);
      wr(REG_BANK, 32'h2);
      wr(REG_MEMADDR, 32'h234);
      wr(REG_MEMDATA, 32'h0B);
      wr(REG_ACC, 32'h05);
      exe(4'h3);
      chk(REG_MEMDATA, 32'h10);
      chk(REG_ACC, 32'h05);
      chk(REG_STATUS, 32'h02);
      wr(REG_PORT, 32'hFF);
      portPins <= 8'h0F;
      wr(REG_ACC, 32'h01);
      exe(4'h4);
      chk(REG_PORT, 32'h10);
      `CHK(secondPortReg, 8'h10)
      wr(REG_TIMER, 32'h20);
      wr(REG_CTRL, 32'h06);
      repeat (100) @(posedge sys_clk);
      wr(REG_ACC, 32'h03);
      exe(4'h5);
      xfer(1'b0, REG_PRESC, 32'h0, rd);
      `CHK(rd, 32'h1)
      chk(REG_TIMER, 32'h23);
      wr(REG_CTRL, 32'h04);
      xfer(1'b0, REG_TIMER, 32'h0, rd);
      xfer(1'b0, REG_TIMER, 32'h0, ip);
      `CHK(ip - rd, 32'h4)
      wr(REG_CTRL, 32'h01);
      wr(REG_INDEX, 32'h300);
      wr(REG_MEMADDR, 32'h35F);
      wr(REG_MEMDATA, 32'h40);
      wr(REG_ACC, 32'h01);
      exe(4'h6);
      chk(REG_ACC, 32'h41);
      wr(REG_MEMADDR, 32'h060);
      wr(REG_MEMDATA, 32'h22);
      exe(4'h7);
      chk(REG_ACC, 32'h63);
      wr(REG_CTRL, 32'h00);
      xfer(1'b0, REG_IPTR, 32'h0, ip);
      exe(4'h8);
      chk(REG_IPTR, ip + 32'h8);
      exe(4'h9);
      chk(REG_STATUS, 32'h200);
      exe(4'hA);
      chk(REG_IPTR, 32'h6824);
      exe(4'hB);
      chk(REG_IPTR, 32'h6826);
      chk(REG_ACC, 32'h63);
      print_verdict();
   end
   `undef CHK
endmodule // add_instruction_execute_tb
`default_nettype wire
